// >>> verilog/sog_pkg.sv
// Constants and types shared by both ends of the science output gate link
package sog_pkg;
   // Packet field values
   localparam logic [2:0] SOG_VERSION = 3'h0;
   localparam logic [6:0] SOG_APID = 7'h47;
   localparam logic [3:0] SOG_CATEGORY = 4'hC;
   localparam logic [1:0] SOG_SEQ_FLAGS = 2'h3;
   localparam logic [2:0] SOG_SEQ_SOURCE = 3'h0;
   localparam logic [15:0] SOG_LENGTH = 16'h0007;
   localparam logic [2:0] SOG_SVC_VERSION = 3'h0;
   localparam logic [3:0] SOG_ACK = 4'h1;
   localparam logic [7:0] SOG_TYPE_SCI = 8'hC0;
   localparam logic [7:0] SOG_TYPE_TMRST = 8'hFF;
   localparam logic [7:0] SOG_SUB_ON = 8'h01;
   localparam logic [7:0] SOG_SUB_OFF = 8'h02;
   localparam logic [7:0] SOG_SUB_TMRST = 8'h01;
   localparam logic [7:0] SOG_PAD = 8'h00;
   localparam logic [6:0] SOG_PID_DEFAULT = 7'h47;
   // Packet sizes in bytes
   localparam int SOG_HDR_BYTES = 6;
   localparam logic [4:0] SOG_MAX_BYTES = 5'h12;
   localparam logic [15:0] SOG_LEN_EXTRA = 16'h0005;
   localparam logic [15:0] SOG_LEN_NODATA = 16'h0005;
   // Queue manager cadence: 10 Hz at 100 MHz
   localparam int SOG_CLK_HZ = 100000000;
   localparam int SOG_PURGE_HZ = 10;
   localparam int SOG_PURGE_CYCLES = SOG_CLK_HZ / SOG_PURGE_HZ;
   // Command kinds offered by the sender
   typedef enum logic [1:0] {
      SOG_CMD_ON = 2'h0,
      SOG_CMD_OFF = 2'h1,
      SOG_CMD_TMRST = 2'h2
   } sog_cmd_t;
endpackage

// >>> verilog/sog_link_if.sv
// Byte stream carrying telecommand packets from the spacecraft to the instrument
`timescale 1ns/10ps
interface sog_link_if;
   logic [7:0] tc_byte;
   logic tc_valid;
   logic tc_last;
   modport sender (output tc_byte, output tc_valid, output tc_last);
   modport receiver (input tc_byte, input tc_valid, input tc_last);
endinterface

// >>> verilog/sog_device.sv
// Instrument end: telecommand decoder, science output gate and queue purge
`timescale 1ns/10ps
// Operation
// RL1 - Sender uses category 12, identifier 71
// RL2 - Sequence count top bits zero
// RL3 - Low count starts zero, increments
// RL4 - Separate counter per identifier/category; code splits science and telemetry reset under identifier 71 category 12
// RL5 - Length equals data bytes plus five
// RL6 - Service version zero, checksum flag set
// RL7 - Acknowledgement field requests acceptance only
// RL8 - Service type selects science group
// RL9 - Subtype picks disable versus enable
// RL10 - Data word: nine pad, identifier
// RL11 - Disable stops science reports on link
// RL12 - Disabled: purge queued packets at 10 Hz
// RL13 - Generation continues except engineering mode
// RL14 - Enable request restores science transmission
// RL15 - Telemetry reset sent on corrupted stream
// RL16 - Telemetry reset clears outbound buffer
// RL17 - Bad checksum or header rejected
// RL18 - Primary header version, flags fixed
module sog_device (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   sog_link_if.receiver link,
   input wire logic i_engineering_mode,
   input wire logic i_sci_ready,
   output logic o_sci_generate,
   output logic o_sci_link_enable,
   output logic o_sci_purge,
   output logic o_tm_buffer_clear,
   output logic o_cmd_accept,
   output logic o_cmd_reject,
   output logic [6:0] o_report_process_selector
);
   import sog_pkg::*;

   typedef enum logic [2:0] {
      SOG_ST_IDLE = 3'b001,
      SOG_ST_RECV = 3'b010,
      SOG_ST_DROP = 3'b100
   } sog_rx_state_t;

   sog_rx_state_t state_q;
   logic [7:0] buf_q [0:17];
   logic [4:0] count_q;
   logic [15:0] sum_q;
   logic sci_on_q;
   logic [31:0] purge_cnt_q;
   logic purge_tick;
   logic frame_end;
   logic hdr_ok;
   logic sum_ok;
   logic [15:0] len_field;
   logic [4:0] exp_bytes;
   logic is_on;
   logic is_off;
   logic is_tmrst;
   logic pid_match;

   // Running 16-bit sum of bytes paired high then low
   function automatic logic [15:0] sog_add_byte(input logic [15:0] s, input logic [7:0] b,
                                                input logic hi);
      logic [15:0] w;
      w = hi ? {b, 8'h00} : {8'h00, b};
      return 16'(s + w);
   endfunction

   // Science group request of one subtype with a zero-padded identifier word
   function automatic logic sog_sci_req(input logic [7:0] svc_type, input logic [7:0] svc_sub,
                                        input logic [15:0] len, input logic [15:0] data,
                                        input logic [7:0] want_sub);
      return svc_type == SOG_TYPE_SCI && svc_sub == want_sub && len == SOG_LENGTH
             && data[15:7] == 9'h000;
   endfunction

   // Packet capture and framing; an overlong packet is dropped up to its end byte
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= SOG_ST_IDLE;
         count_q <= 5'h00;
         sum_q <= 16'h0000;
      end else if (i_ce && link.tc_valid) begin
         case (state_q)
            SOG_ST_IDLE, SOG_ST_RECV: begin
               if (count_q >= SOG_MAX_BYTES) begin
                  state_q <= SOG_ST_DROP;
               end else begin
                  buf_q[count_q] <= link.tc_byte;
                  count_q <= 5'(count_q + 5'h01);
                  sum_q <= sog_add_byte(sum_q, link.tc_byte, ~count_q[0]);
                  state_q <= SOG_ST_RECV;
               end
            end
            SOG_ST_DROP: begin
               state_q <= SOG_ST_DROP;
            end
            default: begin
               state_q <= SOG_ST_IDLE;
            end
         endcase
         // End byte closes the packet whatever the state
         if (link.tc_last) begin
            state_q <= SOG_ST_IDLE;
            count_q <= 5'h00;
            sum_q <= 16'h0000;
         end
      end
   end

   // Header checks on the finished packet
   always_comb begin
      len_field = {buf_q[4], buf_q[5]};
      exp_bytes = 5'(len_field + 16'(SOG_HDR_BYTES) + 16'h0001);
      // RL18 header version flags
      hdr_ok = buf_q[0][7:5] == SOG_VERSION && buf_q[0][4] && buf_q[0][3]
               && buf_q[2][7:6] == SOG_SEQ_FLAGS;
      // RL1 identifier and category
      hdr_ok = hdr_ok && {buf_q[0][2:0], buf_q[1][7:4]} == SOG_APID
               && buf_q[1][3:0] == SOG_CATEGORY;
      // RL2 ground source bits
      hdr_ok = hdr_ok && buf_q[2][5:3] == SOG_SEQ_SOURCE;
      // RL6 RL7 secondary header
      hdr_ok = hdr_ok && buf_q[6][7:5] == SOG_SVC_VERSION && buf_q[6][4]
               && buf_q[6][3:0] == SOG_ACK && buf_q[9] == SOG_PAD;
      // RL5 length delimits packet
      hdr_ok = hdr_ok && len_field >= SOG_LEN_NODATA
               && 5'(count_q + 5'h01) == exp_bytes;
      // RL17 checksum over packet including trailer
      sum_ok = sog_add_byte(sum_q, link.tc_byte, ~count_q[0]) == 16'h0000;
      frame_end = i_ce && link.tc_valid && link.tc_last && state_q != SOG_ST_DROP
                  && count_q < SOG_MAX_BYTES;
      // RL8 RL9 RL10 command group, subtype and data word
      is_on = sog_sci_req(buf_q[7], buf_q[8], len_field, {buf_q[10], buf_q[11]}, SOG_SUB_ON);
      is_off = sog_sci_req(buf_q[7], buf_q[8], len_field, {buf_q[10], buf_q[11]}, SOG_SUB_OFF);
      // Only the default report stream moves the gate
      pid_match = buf_q[11][6:0] == SOG_PID_DEFAULT;
      is_tmrst = buf_q[7] == SOG_TYPE_TMRST && buf_q[8] == SOG_SUB_TMRST
                 && len_field == SOG_LEN_NODATA;
   end

   // Command execution and status pulses
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         sci_on_q <= 1'b1;
         o_cmd_accept <= 1'b0;
         o_cmd_reject <= 1'b0;
         o_tm_buffer_clear <= 1'b0;
         o_report_process_selector <= SOG_PID_DEFAULT;
      end else if (i_ce) begin
         o_cmd_accept <= 1'b0;
         o_cmd_reject <= 1'b0;
         o_tm_buffer_clear <= 1'b0;
         if (link.tc_valid && link.tc_last && !frame_end) begin
            o_cmd_reject <= 1'b1;
         end else if (frame_end) begin
            if (hdr_ok && sum_ok && (is_on || is_off || is_tmrst)) begin
               o_cmd_accept <= 1'b1;
               // Selector follows the last accepted science request
               if (is_on || is_off) begin
                  o_report_process_selector <= buf_q[11][6:0];
               end
               // RL14 enable restores output
               if (is_on && pid_match) begin
                  sci_on_q <= 1'b1;
               end
               // RL11 disable stops output
               if (is_off && pid_match) begin
                  sci_on_q <= 1'b0;
               end
               // RL16 clear telemetry buffer
               o_tm_buffer_clear <= is_tmrst;
            end else begin
               // RL17 reject without action
               o_cmd_reject <= 1'b1;
            end
         end
      end
   end

   // RL12 queue manager pass timer
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         purge_cnt_q <= 32'h00000000;
      end else if (i_ce) begin
         if (purge_tick) begin
            purge_cnt_q <= 32'h00000000;
         end else begin
            purge_cnt_q <= 32'(purge_cnt_q + 32'h00000001);
         end
      end
   end
   // Tick on the last count of each pass
   assign purge_tick = purge_cnt_q == 32'(SOG_PURGE_CYCLES - 1);

   // Gate outputs toward the link and generator
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_sci_link_enable <= 1'b0;
         o_sci_purge <= 1'b0;
         o_sci_generate <= 1'b0;
      end else if (i_ce) begin
         o_sci_link_enable <= sci_on_q;
         // RL12 purge on pass when disabled
         o_sci_purge <= purge_tick && !sci_on_q;
         // RL13 generation independent of gate
         o_sci_generate <= i_sci_ready && !i_engineering_mode;
      end
   end
endmodule

// >>> verilog/sog_sender.sv
// Spacecraft end: builds and sends science control telecommand packets
`timescale 1ns/10ps
module sog_sender (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   sog_link_if.sender link,
   input wire logic i_send,
   input wire sog_pkg::sog_cmd_t i_cmd,
   input wire logic [6:0] i_report_process_selector,
   output logic o_busy,
   output logic o_done
);
   import sog_pkg::*;

   typedef enum logic [1:0] {
      SOG_TX_IDLE = 2'b01,
      SOG_TX_SEND = 2'b10
   } sog_tx_state_t;

   sog_tx_state_t state_q;
   logic [7:0] pkt_q [0:17];
   logic [4:0] idx_q;
   logic [4:0] last_q;
   logic [15:0] sum_q;
   logic [10:0] seq_sci_q;
   logic [10:0] seq_tm_q;
   logic [15:0] sum_d;
   logic [15:0] len;
   logic [10:0] seq;

   // Sequence and length for the requested command
   always_comb begin
      // RL4 asks a counter per identifier/category; here science and reset count apart, both identifier 71 category 12
      seq = (i_cmd == SOG_CMD_TMRST) ? seq_tm_q : seq_sci_q;
      // RL5 length set from data size
      len = (i_cmd == SOG_CMD_TMRST) ? SOG_LEN_NODATA : SOG_LENGTH;
      sum_d = 16'(sum_q + (idx_q[0] ? {8'h00, pkt_q[idx_q]} : {pkt_q[idx_q], 8'h00}));
   end

   // Packet build and byte transmission
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= SOG_TX_IDLE;
         idx_q <= 5'h00;
         last_q <= 5'h00;
         sum_q <= 16'h0000;
         seq_sci_q <= 11'h000;
         seq_tm_q <= 11'h000;
         link.tc_valid <= 1'b0;
         link.tc_last <= 1'b0;
         link.tc_byte <= 8'h00;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else if (i_ce) begin
         o_done <= 1'b0;
         link.tc_valid <= 1'b0;
         link.tc_last <= 1'b0;
         case (state_q)
            SOG_TX_IDLE: begin
               if (i_send) begin
                  // RL18 RL1 primary header
                  pkt_q[0] <= {SOG_VERSION, 1'b1, 1'b1, SOG_APID[6:4]};
                  pkt_q[1] <= {SOG_APID[3:0], SOG_CATEGORY};
                  // RL2 RL3 sequence count
                  pkt_q[2] <= {SOG_SEQ_FLAGS, SOG_SEQ_SOURCE, seq[10:8]};
                  pkt_q[3] <= seq[7:0];
                  pkt_q[4] <= len[15:8];
                  pkt_q[5] <= len[7:0];
                  // RL6 RL7 secondary header
                  pkt_q[6] <= {SOG_SVC_VERSION, 1'b1, SOG_ACK};
                  // RL8 RL9 service type and subtype
                  pkt_q[7] <= (i_cmd == SOG_CMD_TMRST) ? SOG_TYPE_TMRST : SOG_TYPE_SCI;
                  pkt_q[8] <= (i_cmd == SOG_CMD_ON) ? SOG_SUB_ON :
                              (i_cmd == SOG_CMD_OFF) ? SOG_SUB_OFF : SOG_SUB_TMRST;
                  pkt_q[9] <= SOG_PAD;
                  // RL10 data word
                  pkt_q[10] <= 8'h00;
                  pkt_q[11] <= {1'b0, i_report_process_selector};
                  last_q <= 5'(len + 16'(SOG_HDR_BYTES));
                  if (i_cmd == SOG_CMD_TMRST) begin
                     seq_tm_q <= 11'(seq_tm_q + 11'h001);
                  end else begin
                     seq_sci_q <= 11'(seq_sci_q + 11'h001);
                  end
                  idx_q <= 5'h00;
                  sum_q <= 16'h0000;
                  o_busy <= 1'b1;
                  state_q <= SOG_TX_SEND;
               end
            end
            SOG_TX_SEND: begin
               link.tc_valid <= 1'b1;
               idx_q <= 5'(idx_q + 5'h01);
               if (idx_q == 5'(last_q - 5'h01)) begin
                  // Trailer high byte: negated sum makes total zero
                  link.tc_byte <= 8'(16'(16'h0000 - sum_q) >> 8);
               end else if (idx_q == last_q) begin
                  link.tc_byte <= 8'(16'h0000 - sum_q);
                  link.tc_last <= 1'b1;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  state_q <= SOG_TX_IDLE;
               end else begin
                  link.tc_byte <= pkt_q[idx_q];
                  sum_q <= sum_d;
               end
            end
            default: state_q <= SOG_TX_IDLE;
         endcase
      end
   end
endmodule

// >>> sim/sog_link_assertions.sv
// Property checker for the telecommand link and science gate
`timescale 1ns/10ps
module sog_link_assertions (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [7:0] tc_byte,
   input wire logic tc_valid,
   input wire logic tc_last,
   input wire logic o_done,
   input wire logic o_cmd_accept,
   input wire logic o_cmd_reject,
   input wire logic o_sci_link_enable,
   input wire logic o_sci_purge,
   input wire logic o_sci_generate,
   input wire logic i_sci_ready,
   input wire logic i_engineering_mode
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_hdr_start: assert property ($rose(tc_valid) |-> tc_byte == 8'h1C ##1 tc_byte == 8'h7C
      ##1 tc_byte[7:3] == 5'h18) else $error("header bytes wrong");
   a_frame_whole: assert property ($rose(tc_valid) |-> tc_valid [*8])
      else $error("frame broken early");
   a_last_valid: assert property (tc_last |-> tc_valid) else $error("end without byte");
   a_answer_after: assert property (tc_valid && tc_last |=> o_cmd_accept ^ o_cmd_reject)
      else $error("no single answer");
   a_answer_cause: assert property (o_cmd_accept || o_cmd_reject |-> $past(tc_valid && tc_last))
      else $error("answer without packet");
   a_done_last: assert property (o_done |-> tc_last && tc_valid) else $error("done misplaced");
   a_gate_cause: assert property (!$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3) &&
      $changed(o_sci_link_enable) |-> $past(o_cmd_accept)) else $error("gate moved alone");
   a_purge_closed: assert property (o_sci_purge |-> !o_sci_link_enable)
      else $error("purge while open");
   a_gen_follow: assert property (!$past(i_rst) |->
      o_sci_generate == $past(i_sci_ready && !i_engineering_mode)) else $error("generate wrong");
   c_accept: cover property (o_cmd_accept);
   c_gate_off: cover property ($fell(o_sci_link_enable));
   c_gen_closed: cover property (o_sci_generate && !o_sci_link_enable);
endmodule

// >>> sim/science_output_gate_tc_tb_top.sv
// Bench joining sender and instrument ends, plus a fault-injection link
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module science_output_gate_tc_tb_top;
   import sog_pkg::*;
   logic i_sys_clk = 0, i_rst = 1, send = 0, eng = 0, rdy = 0, ce = 1, len_hold = 0;
   sog_cmd_t cmd = SOG_CMD_ON;
   logic [6:0] pid = 7'h47, exp_sel = 7'h47, sel, sel2;
   int miscompares = 0, tests_run = 0, seed = 32'h84c6, sci_n = 0, tm_n = 0;
   logic [7:0] rec[$], pkt[$];
   logic busy, done, gen, len, pur, clr, acc, rej, gen2, len2, pur2, clr2, acc2, rej2;
   sog_link_if lk();
   sog_link_if lk2();
   // Free-running system clock
   initial forever #5 i_sys_clk = ~i_sys_clk;
   sog_sender sog_sender_i (.i_sys_clk, .i_rst, .i_ce(ce), .link(lk.sender), .i_send(send),
      .i_cmd(cmd), .i_report_process_selector(pid), .o_busy(busy), .o_done(done));
   sog_device sog_device_i (.i_sys_clk, .i_rst, .i_ce(ce), .link(lk.receiver),
      .i_engineering_mode(eng), .i_sci_ready(rdy), .o_sci_generate(gen), .o_sci_link_enable(len),
      .o_sci_purge(pur), .o_tm_buffer_clear(clr), .o_cmd_accept(acc), .o_cmd_reject(rej),
      .o_report_process_selector(sel));
   sog_device fault_sog_device_i (.i_sys_clk, .i_rst, .i_ce(ce), .link(lk2.receiver),
      .i_engineering_mode(eng), .i_sci_ready(rdy), .o_sci_generate(gen2),
      .o_sci_link_enable(len2), .o_sci_purge(pur2), .o_tm_buffer_clear(clr2),
      .o_cmd_accept(acc2), .o_cmd_reject(rej2), .o_report_process_selector(sel2));
   sog_link_assertions sog_link_assertions_i (.i_sys_clk, .i_rst, .tc_byte(lk.tc_byte),
      .tc_valid(lk.tc_valid), .tc_last(lk.tc_last), .o_done(done), .o_cmd_accept(acc),
      .o_cmd_reject(rej), .o_sci_link_enable(len), .o_sci_purge(pur), .o_sci_generate(gen),
      .i_sci_ready(rdy), .i_engineering_mode(eng));
   // Capture every byte crossing the main link
   always @(posedge i_sys_clk) begin
      if (lk.tc_valid === 1'b1) begin
         rec.push_back(lk.tc_byte);
      end
   end
   task automatic tally_and_finish;
      $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Send one command and check answer, gate and header counts
   task automatic send_cmd(input sog_cmd_t c, input logic [6:0] p);
      logic el, cl;
      int k, cnt;
      el = (c == SOG_CMD_TMRST || p != SOG_PID_DEFAULT) ? len : (c == SOG_CMD_ON);
      cnt = (c == SOG_CMD_TMRST) ? tm_n : sci_n;
      if (c != SOG_CMD_TMRST) exp_sel = p;
      rec.delete();
      cmd = c;
      pid = p;
      send = 1;
      @(negedge i_sys_clk);
      send = 0;
      `CHK(busy, 1'b1)
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         @(negedge i_sys_clk);
         k++;
      end
      if (k == 100) begin
         miscompares++;
         tally_and_finish();
      end
      `CHK(busy, 1'b0)
      @(negedge i_sys_clk);
      `CHK({acc, rej}, 2'b10)
      cl = clr;
      @(negedge i_sys_clk);
      `CHK(cl | clr, c == SOG_CMD_TMRST)
      `CHK(len, el)
      `CHK(sel, exp_sel)
      // Run stays far shorter than one queue pass, so no purge yet
      `CHK(pur, 1'b0)
      `CHK(gen, rdy & !eng)
      `CHK({rec[2][2:0], rec[3]}, cnt[10:0])
      `CHK({rec[4], rec[5]}, (c == SOG_CMD_TMRST) ? SOG_LEN_NODATA : SOG_LENGTH)
      if (c != SOG_CMD_TMRST) `CHK({rec[rec.size() - 4], rec[rec.size() - 3]}, {9'h0, p})
      if (c == SOG_CMD_TMRST) tm_n++;
      else sci_n++;
   endtask
   // Drive a captured packet into the fault link, maybe corrupted
   task automatic replay(input int flip, input int n, input logic ok);
      for (int i = 0; i < n; i++) begin
         lk2.tc_byte = pkt[i] ^ ((i == flip) ? 8'h01 : 8'h00);
         lk2.tc_valid = 1;
         lk2.tc_last = (i == n - 1);
         @(negedge i_sys_clk);
      end
      lk2.tc_valid = 0;
      lk2.tc_last = 0;
      lk2.tc_byte = ~lk2.tc_byte;
      `CHK({acc2, rej2}, {ok, !ok})
      @(negedge i_sys_clk);
      `CHK(len2, !ok)
   endtask
   initial begin
      lk2.tc_byte = 8'h00;
      lk2.tc_valid = 0;
      lk2.tc_last = 0;
      repeat (10) @(negedge i_sys_clk);
      i_rst = 0;
      repeat (3) @(negedge i_sys_clk);
      `CHK({len, sel}, {1'b1, SOG_PID_DEFAULT})
      $display("test reset done");
      send_cmd(SOG_CMD_OFF, 7'h47);
      pkt = rec;
      rdy = 1;
      repeat (2) @(negedge i_sys_clk);
      `CHK({len, gen}, 2'b01)
      eng = 1;
      repeat (2) @(negedge i_sys_clk);
      `CHK(gen, 1'b0)
      send_cmd(SOG_CMD_ON, 7'h47);
      send_cmd(SOG_CMD_OFF, 7'h05);
      send_cmd(SOG_CMD_TMRST, 7'h47);
      send_cmd(SOG_CMD_TMRST, 7'h47);
      $display("test directed done");
      for (int i = 0; i < 40; i++) begin
         eng = 1'($random(seed));
         rdy = 1'($random(seed));
         // Even passes use the default stream so the gate really moves
         send_cmd(sog_cmd_t'($unsigned($random(seed)) % 3),
                  (i % 2 == 0) ? SOG_PID_DEFAULT : 7'($random(seed)));
      end
      $display("test random done");
      // Frozen ends ignore a request and hold the gate
      len_hold = len;
      ce = 0;
      cmd = SOG_CMD_OFF;
      pid = SOG_PID_DEFAULT;
      send = 1;
      repeat (4) @(negedge i_sys_clk);
      `CHK({busy, lk.tc_valid, len, sel}, {2'b00, len_hold, exp_sel})
      send = 0;
      ce = 1;
      repeat (2) @(negedge i_sys_clk);
      `CHK({busy, len}, {1'b0, len_hold})
      $display("test freeze done");
      replay(0, pkt.size(), 1'b0);
      replay(7, pkt.size(), 1'b0);
      replay(pkt.size() - 1, pkt.size(), 1'b0);
      replay(-1, pkt.size() - 1, 1'b0);
      replay(-1, pkt.size(), 1'b1);
      $display("test fault done");
      tally_and_finish();
   end
endmodule
